// ===== cam_axil_slave.sv
`timescale 1ns/1ps
// ********************************************************
// AXI4-Lite slave front end, one write and one read at a time
// ********************************************************
module cam_axil_slave (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // Write address and data
  input  wire logic [cam_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // Write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // Read address and data
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Register side
  output logic                           wrEn,
  output logic [cam_pkg::ADDR_W-1:0]     wrAddr,
  output logic [31:0]                    wrData,
  output logic [3:0]                     wrStrb,
  input  wire logic                      wrOk,
  input  wire logic [31:0]               rdData,
  input  wire logic                      rdOk
);
  import cam_pkg::*;

  logic awHeld_q, awHeld_d;  // Write address captured
  logic wHeld_q,  wHeld_d;   // Write data captured
  logic awRdy_q,  awRdy_d;
  logic wRdy_q,   wRdy_d;
  logic bValid_q, bValid_d;
  logic [1:0] bResp_q;
  logic arRdy_q,  arRdy_d;
  logic rValid_q, rValid_d;
  logic [1:0] rResp_q;
  logic [31:0] rData_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic awTake, wTake, arTake;

  // Handshake decode
  assign awTake   = s_axi_awvalid & awRdy_q;
  assign wTake    = s_axi_wvalid & wRdy_q;
  assign arTake   = s_axi_arvalid & arRdy_q;
  assign wrEn     = awHeld_q & wHeld_q;
  assign awHeld_d = awHeld_q ? ~wrEn : awTake;
  assign wHeld_d  = wHeld_q ? ~wrEn : wTake;
  assign bValid_d = bValid_q ? ~s_axi_bready : wrEn;
  assign awRdy_d  = ~awHeld_d & ~bValid_d;
  assign wRdy_d   = ~wHeld_d & ~bValid_d;
  assign rValid_d = rValid_q ? ~s_axi_rready : arTake;
  assign arRdy_d  = ~rValid_d;

  // Write channel state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awRdy_q  <= 1'b1;
      wRdy_q   <= 1'b1;
      bValid_q <= 1'b0;
      bResp_q  <= RESP_OKAY;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q  <= wHeld_d;
      awRdy_q  <= awRdy_d;
      wRdy_q   <= wRdy_d;
      bValid_q <= bValid_d;
      if (wrEn) begin
        bResp_q <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Captured write payload
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      awAddr_q <= '0;
      wData_q  <= '0;
      wStrb_q  <= '0;
    end else begin
      if (awTake) begin
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
    end
  end

  // Read channel: data registered at the address handshake
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      arRdy_q  <= 1'b1;
      rValid_q <= 1'b0;
      rResp_q  <= RESP_OKAY;
      rData_q  <= '0;
    end else begin
      arRdy_q  <= arRdy_d;
      rValid_q <= rValid_d;
      if (arTake) begin
        rData_q <= rdOk ? rdData : '0;
        rResp_q <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign wrAddr        = awAddr_q;
  assign wrData        = wData_q;
  assign wrStrb        = wStrb_q;
  assign s_axi_awready = awRdy_q;
  assign s_axi_wready  = wRdy_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arRdy_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

endmodule : cam_axil_slave

// ===== cam_mask_match.sv
`timescale 1ns/1ps
// ********************************************************
// Combinational compare of one frame identifier with a filter
// ********************************************************
module cam_mask_match (
  // Compare operands
  input  wire cam_pkg::cam_id_s   msgId,
  input  wire cam_pkg::cam_id_s   fltId,
  input  wire cam_pkg::cam_mask_s mask,
  // Result
  output logic                    hit
);
  import cam_pkg::*;

  logic sidOk;   // Selected standard bits agree
  logic eidOk;   // Selected extended bits agree
  logic idOk;    // Identifier part agrees
  logic typeOk;  // Frame format agrees where required

  // Set mask bit means the bit must match, clear means ignored
  assign sidOk  = ((msgId.std_id_mask_bits ^ fltId.std_id_mask_bits) & mask.stdIdMaskBits) == '0;
  assign eidOk  = ((msgId.ext_id_mask_bits ^ fltId.ext_id_mask_bits) & mask.extIdMaskBits) == '0;
  // Extended filters also compare the extended part
  assign idOk   = fltId.ext ? (sidOk & eidOk) : sidOk;
  // Type mode demands format equal to the filter's selection
  assign typeOk = ~mask.idTypeMatchMode | (msgId.ext == fltId.ext);
  assign hit    = idOk & typeOk;

endmodule : cam_mask_match

// ===== cam_pkg.sv
// ********************************************************
// Shared constants and types for the acceptance mask block
// ********************************************************
package cam_pkg;

  // Mask count and identifier widths
  localparam int NUM_MASKS = 3;
  localparam int SID_W     = 11;
  localparam int EID_W     = 18;
  localparam int REG_W     = 16;
  localparam int ADDR_W    = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STD0   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EXT0   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAT   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;

  // Field positions in the standard-identifier mask word
  localparam int STD_SID_LSB = 5;
  localparam int STD_ID_TYPE_MATCH_MODE    = 3;
  localparam int STD_EID_HI  = 0;

  // Writable bits of the standard word; bits 4 and 2 stay zero
  localparam logic [REG_W-1:0] STD_WMASK = 16'hffeb;

  // Values after reset
  localparam logic [REG_W-1:0] RST_MASK = 16'h0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Identifier as carried by a frame or a filter
  typedef struct packed {
    logic             ext;  // Extended format / filter_ext_frame_select
    logic [SID_W-1:0] std_id_mask_bits;
    logic [EID_W-1:0] ext_id_mask_bits;
  } cam_id_s;

  // One acceptance mask, unpacked from its two registers
  typedef struct packed {
    logic             idTypeMatchMode;
    logic [SID_W-1:0] stdIdMaskBits;
    logic [EID_W-1:0] extIdMaskBits;
  } cam_mask_s;

  // Address decode result
  typedef struct packed {
    logic       std;
    logic       ext;
    logic       stat;
    logic [1:0] idx;
  } cam_dec_s;

endpackage : cam_pkg

// ===== cam_rx_feed.sv
`timescale 1ns/1ps
// ****************************************
// Receive path model feeding frame and filter identifiers
// ****************************************
module cam_rx_feed (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Commands from the bench
  input  wire logic             cmdValid,
  input  wire cam_pkg::cam_id_s cmdMsg,
  input  wire cam_pkg::cam_id_s cmdFlt,
  // Toward the mask block
  output logic                  rxValid,
  output cam_pkg::cam_id_s      rxId,
  output cam_pkg::cam_id_s      fltId
);
  import cam_pkg::*;

  // Launches one identifier pair per command cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rxValid <= 1'b0;
      rxId    <= '0;
      fltId   <= '0;
    end else if (cmdValid) begin
      // Qualified pair, held for exactly one cycle
      rxValid <= 1'b1;
      rxId    <= cmdMsg;
      fltId   <= cmdFlt;
    end else begin
      // Idle lines toggle so a stale pair can never look valid
      rxValid <= 1'b0;
      rxId    <= ~rxId;
      fltId   <= ~fltId;
    end
  end
endmodule : cam_rx_feed

// ===== cam_top.sv
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - Three independent masks, identical register layout
// - Standard mask bit set demands match
// - Type mode set: format must equal filter
// - Type mode clear: either format may match
// - Low mask bits cover extended bits 17-16
// - Bits four and two read zero
// - Companion register masks extended bits 15-0
module cam_top (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset,
  // AXI4-Lite write address and data
  input  wire logic [cam_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read
  input  wire logic [cam_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Receive path: frame identifier and filter under test
  input  wire logic                       rxValid,
  input  wire cam_pkg::cam_id_s           rxId,
  input  wire cam_pkg::cam_id_s           fltId,
  // Match result, one bit per mask
  output logic                            hitValid,
  output logic [cam_pkg::NUM_MASKS-1:0]   hitVec
);
  import cam_pkg::*;

  // ********************************************************
  // Register storage and bus wiring
  // ********************************************************
  logic [REG_W-1:0]     stdMask_q [NUM_MASKS];  // Standard mask words
  logic [REG_W-1:0]     extMask_q [NUM_MASKS];  // Extended mask words
  cam_mask_s            mask      [NUM_MASKS];  // Unpacked masks
  logic [NUM_MASKS-1:0] hitNow;                 // Live compare result
  logic [NUM_MASKS-1:0] hitVec_q;               // Registered result
  logic                 hitValid_q;             // Result qualifier
  logic [NUM_MASKS-1:0] lastHit_q;              // Status copy
  logic                 wrEn;                   // Register write pulse
  logic [ADDR_W-1:0]    wrAddr;                 // Write address
  logic [31:0]          wrData;                 // Write data
  logic [3:0]           wrStrb;                 // Write byte lanes
  logic [REG_W-1:0]     laneMask;               // Strobes as bit mask
  cam_dec_s             wrDec;                  // Write decode
  cam_dec_s             rdDec;                  // Read decode
  logic                 wrOk;                   // Write hits a register
  logic                 rdOk;                   // Read hits a register
  logic [REG_W-1:0]     rdWord;                 // Selected read word
  logic [31:0]          rdData;                 // Read data to slave

  // Maps a byte address to a register, one function for both ports
  function automatic cam_dec_s decodeAddr(input logic [ADDR_W-1:0] a);
    cam_dec_s d;
    d = '0;
    for (int i = 0; i < NUM_MASKS; i++) begin
      if (a == OFS_STD0 + ADDR_W'(i) * REG_STRIDE) begin
        d.std = 1'b1;
        d.idx = 2'(i);
      end
      if (a == OFS_EXT0 + ADDR_W'(i) * REG_STRIDE) begin
        d.ext = 1'b1;
        d.idx = 2'(i);
      end
    end
    d.stat = (a == OFS_STAT);
    return d;
  endfunction : decodeAddr

  // ********************************************************
  // Bus slave
  // ********************************************************
  cam_axil_slave u_slave (
    .clock         (clock),
    .reset         (reset),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrEn          (wrEn),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrStrb        (wrStrb),
    .wrOk          (wrOk),
    .rdData        (rdData),
    .rdOk          (rdOk)
  );

  // Decode both ports; status is read-only but a write is accepted
  assign wrDec    = decodeAddr(wrAddr);
  assign rdDec    = decodeAddr(s_axi_araddr);
  assign wrOk     = wrDec.std | wrDec.ext | wrDec.stat;
  assign rdOk     = rdDec.std | rdDec.ext | rdDec.stat;
  assign laneMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};

  // Read mux; unimplemented bits come back as zero
  assign rdWord = rdDec.std  ? (stdMask_q[rdDec.idx] & STD_WMASK) :
                  rdDec.ext  ? extMask_q[rdDec.idx] :
                  rdDec.stat ? REG_W'(lastHit_q) : '0;
  assign rdData = {16'h0000, rdWord};

  // ********************************************************
  // Mask registers, one pair per mask
  // ********************************************************
  for (genvar n = 0; n < NUM_MASKS; n++) begin : g_mask
    logic wrStd;  // This mask's standard word is written
    logic wrExt;  // This mask's extended word is written

    assign wrStd = wrEn & wrDec.std & (wrDec.idx == 2'(n));
    assign wrExt = wrEn & wrDec.ext & (wrDec.idx == 2'(n));

    // Byte-lane write; unimplemented bits never take a one
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        stdMask_q[n] <= RST_MASK;
        extMask_q[n] <= RST_MASK;
      end else begin
        if (wrStd) begin
          stdMask_q[n] <= ((stdMask_q[n] & ~laneMask) |
                           (wrData[REG_W-1:0] & laneMask)) & STD_WMASK;
        end
        if (wrExt) begin
          extMask_q[n] <= (extMask_q[n] & ~laneMask) |
                          (wrData[REG_W-1:0] & laneMask);
        end
      end
    end

    // Unpack fields of the two words into one mask
    assign mask[n].stdIdMaskBits   = stdMask_q[n][STD_SID_LSB +: SID_W];
    assign mask[n].idTypeMatchMode = stdMask_q[n][STD_ID_TYPE_MATCH_MODE];
    assign mask[n].extIdMaskBits   = {stdMask_q[n][STD_EID_HI +: 2],
                                      extMask_q[n]};

    // One comparator per mask, evaluated on the live identifier
    cam_mask_match u_match (
      .msgId (rxId),
      .fltId (fltId),
      .mask  (mask[n]),
      .hit   (hitNow[n])
    );
  end

  // ********************************************************
  // Result registers
  // ********************************************************
  // Capture the compare result of each offered identifier
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hitValid_q <= 1'b0;
      hitVec_q   <= '0;
      lastHit_q  <= '0;
    end else begin
      hitValid_q <= rxValid;
      hitVec_q   <= rxValid ? hitNow : '0;
      if (rxValid) begin
        lastHit_q <= hitNow;
      end
    end
  end

  assign hitValid = hitValid_q;
  assign hitVec   = hitVec_q;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic [SID_W-1:0] sidDiff0;  // Mask 0 selected standard mismatch
  logic [EID_W-1:0] eidDiff0;  // Mask 0 selected extended mismatch
  assign sidDiff0 = (rxId.std_id_mask_bits ^ fltId.std_id_mask_bits) & mask[0].stdIdMaskBits;
  assign eidDiff0 = (rxId.ext_id_mask_bits ^ fltId.ext_id_mask_bits) & mask[0].extIdMaskBits;

  chk_mask_indep: assert property (
    wrEn && wrDec.std && wrDec.idx == 2'd1 |=>
      $stable(stdMask_q[0]) && $stable(stdMask_q[2]))
    else $error("Writing mask 1 disturbed another mask");

  chk_sid_mismatch: assert property (
    rxValid && sidDiff0 != '0 |=> hitValid && !hitVec[0])
    else $error("Masked standard mismatch still hit");

  chk_type_mode: assert property (
    rxValid && mask[0].idTypeMatchMode && rxId.ext != fltId.ext
      |=> !hitVec[0])
    else $error("Type mode let a wrong format pass");

  chk_any_format: assert property (
    rxValid && !mask[0].idTypeMatchMode && !fltId.ext && sidDiff0 == '0
      |=> hitVec[0])
    else $error("Standard match refused with type mode clear");

  chk_eid_high: assert property (
    wrEn && wrDec.std && wrDec.idx == 2'd0 && wrStrb[0] |=>
      mask[0].extIdMaskBits[EID_W-1 -: 2] == $past(wrData[1:0]))
    else $error("Extended bits 17-16 mask not stored");

  chk_zero_bits: assert property (
    s_axi_arvalid && s_axi_arready && rdDec.std |=>
      s_axi_rvalid && s_axi_rdata[4] == 1'b0 && s_axi_rdata[2] == 1'b0)
    else $error("Unimplemented bits read nonzero");

  chk_ext_store: assert property (
    wrEn && wrDec.ext && wrDec.idx == 2'd2 && wrStrb[1:0] == 2'b11 |=>
      extMask_q[2] == $past(wrData[REG_W-1:0]))
    else $error("Extended mask word not stored");

  chk_full_match: assert property (
    rxValid && fltId.ext && !mask[0].idTypeMatchMode &&
      sidDiff0 == '0 && eidDiff0 == '0 |=> hitVec[0])
    else $error("Full identifier match did not hit");

  chk_ext_mismatch: assert property (
    rxValid && fltId.ext && eidDiff0 != '0 |=> !hitVec[0])
    else $error("Extended mismatch on extended filter hit");

  // Result is a one-cycle pulse that follows each offered identifier
  chk_hit_pulse: assert property (
    !rxValid |=> !hitValid && hitVec == '0)
    else $error("Result shown without an offered identifier");

  // Status keeps the last result for software
  chk_status_copy: assert property (
    rxValid |=> lastHit_q == hitVec)
    else $error("Status copy differs from the result");

  // Extended mask word never reaches the standard word
  chk_ext_indep: assert property (
    wrEn && wrDec.ext |=> $stable(stdMask_q[0]) && $stable(stdMask_q[1]))
    else $error("Extended write disturbed a standard mask");

endmodule : cam_top

// ===== test_can_acceptance_mask_std_id.sv
`timescale 1ns/1ps
module test_can_acceptance_mask_std_id;
  import cam_pkg::*;

  // One table row: mask words, frame, filter, expected hit
  typedef struct packed {
    logic [15:0] stdW;
    logic [15:0] extW;
    cam_id_s     msg;
    cam_id_s     flt;
    logic        hit;
  } cam_row_s;

  // ****************************************
  // Signals
  // ****************************************
  logic              clock, reset;
  logic [ADDR_W-1:0] awAddr, arAddr;
  logic              awValid, wValid, bReady, arValid, rReady;
  logic              awReady, wReady, bValid, arReady, rValid;
  logic [31:0]       wData, rData, rd;
  logic [3:0]        wStrb;
  logic [1:0]        bResp, rResp, rs;
  logic              cmdValid, rxValid, hitValid;
  cam_id_s           cmdMsg, cmdFlt, rxId, fltId;
  logic [2:0]        hitVec, hv;
  int                fails, totalChecks, cycles, n;
  cam_row_s          rows [11];
  logic [15:0]       expRb [6];

  // ****************************************
  // Instances
  // ****************************************
  cam_top cam_top_inst (
    .clock(clock), .reset(reset),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .rxValid(rxValid), .rxId(rxId), .fltId(fltId),
    .hitValid(hitValid), .hitVec(hitVec)
  );
  cam_rx_feed cam_rx_feed_inst (
    .clock(clock), .reset(reset), .cmdValid(cmdValid),
    .cmdMsg(cmdMsg), .cmdFlt(cmdFlt),
    .rxValid(rxValid), .rxId(rxId), .fltId(fltId)
  );

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  // Free running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cuts a hang short well beyond the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Builds an identifier from format, standard and extended parts
  function automatic cam_id_s mk(logic e, logic [10:0] s, logic [17:0] x);
    return {e, s, x};
  endfunction : mk

  // Compares a seen value with the expected one
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Bus write: address and data offered together, released when taken
  task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clock);
    awAddr  <= a;
    awValid <= 1'b1;
    wData   <= d;
    wStrb   <= s;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (bValid) begin
        done = 1'b1;
        bReady <= 1'b0;
        check("bresp", {30'h0, bResp}, {30'h0, er});
      end
    end
  endtask : wrReg

  // Bus read: data and response taken at the rvalid edge
  task automatic rdReg(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clock);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (arReady) arValid <= 1'b0;
      if (rValid) begin
        done = 1'b1;
        d = rData;
        r = rResp;
        rReady <= 1'b0;
      end
    end
  endtask : rdReg

  // One frame through the receive model; result one cycle later
  task automatic frame(input cam_id_s m, input cam_id_s f,
                       output logic [2:0] v);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdMsg   <= m;
    cmdFlt   <= f;
    @(posedge clock);
    cmdValid <= 1'b0;
    @(posedge clock);
    #1;
    check("hitValid", {31'h0, hitValid}, 32'h1);
    v = hitVec;
  endtask : frame

  // Prints the counts and the verdict, then ends the run
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {reset, awValid, wValid, bReady, arValid, rReady, cmdValid} = 7'h40;
    {awAddr, arAddr, wData, wStrb} = '0;
    cmdMsg = '0;
    cmdFlt = '0;
    fails = 0;
    totalChecks = 0;
    cycles = 0;
    rows[0]  = '{16'hffe0, 16'h0000, mk(1'b0, 11'h123, 18'h0),
                 mk(1'b0, 11'h123, 18'h0), 1'b1};
    rows[1]  = '{16'hffe0, 16'h0000, mk(1'b0, 11'h123, 18'h0),
                 mk(1'b0, 11'h122, 18'h0), 1'b0};
    rows[2]  = '{16'hffc0, 16'h0000, mk(1'b0, 11'h123, 18'h0),
                 mk(1'b0, 11'h122, 18'h0), 1'b1};
    rows[3]  = '{16'h0008, 16'h0000, mk(1'b1, 11'h0, 18'h0),
                 mk(1'b0, 11'h0, 18'h0), 1'b0};
    rows[4]  = '{16'h0008, 16'h0000, mk(1'b1, 11'h0, 18'h5),
                 mk(1'b1, 11'h0, 18'h0), 1'b1};
    rows[5]  = '{16'h0000, 16'h0000, mk(1'b1, 11'h0, 18'h0),
                 mk(1'b0, 11'h0, 18'h0), 1'b1};
    rows[6]  = '{16'h0001, 16'h0000, mk(1'b1, 11'h0, 18'h10000),
                 mk(1'b1, 11'h0, 18'h0), 1'b0};
    rows[7]  = '{16'h0002, 16'h0000, mk(1'b1, 11'h0, 18'h10000),
                 mk(1'b1, 11'h0, 18'h0), 1'b1};
    rows[8]  = '{16'h0000, 16'h0001, mk(1'b1, 11'h0, 18'h1),
                 mk(1'b1, 11'h0, 18'h0), 1'b0};
    rows[9]  = '{16'h0000, 16'hfffe, mk(1'b1, 11'h0, 18'h1),
                 mk(1'b1, 11'h0, 18'h0), 1'b1};
    rows[10] = '{16'h0001, 16'h0000, mk(1'b0, 11'h0, 18'h10000),
                 mk(1'b0, 11'h0, 18'h0), 1'b1};
    expRb = '{16'h0000, 16'h0001, 16'h0000, 16'hfffe, 16'h0000, 16'h0001};
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    // Every mask word and the status start cleared
    for (int i = 0; i < 7; i++) begin
      rdReg(8'(i * 4), rd, rs);
      check("resetValue", rd, 32'h0);
    end
    // Table: program one mask per row, then present the frame
    for (int i = 0; i < 11; i++) begin
      n = i % 3;
      wrReg(8'(n * 4), {16'h0, rows[i].stdW}, 4'hf, RESP_OKAY);
      wrReg(OFS_EXT0 + 8'(n * 4), {16'h0, rows[i].extW}, 4'hf, RESP_OKAY);
      frame(rows[i].msg, rows[i].flt, hv);
      check("hitBit", {31'h0, hv[n]}, {31'h0, rows[i].hit});
    end
    // Each mask keeps its own last value
    for (int i = 0; i < 6; i++) begin
      rdReg(8'(i * 4), rd, rs);
      check("readback", rd, {16'h0, expRb[i]});
    end
    // Back-to-back frames give back-to-back results
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdMsg   <= mk(1'b1, 11'h0, 18'h0);
    cmdFlt   <= mk(1'b1, 11'h0, 18'h0);
    @(posedge clock);
    cmdMsg   <= mk(1'b1, 11'h0, 18'h1);
    @(posedge clock);
    cmdValid <= 1'b0;
    #1;
    check("hitFirst", {28'h0, hitValid, hitVec}, 32'hf);
    @(posedge clock);
    #1;
    check("hitSecond", {28'h0, hitValid, hitVec}, 32'hb);
    @(posedge clock);
    #1;
    check("hitIdle", {28'h0, hitValid, hitVec}, 32'h0);
    rdReg(OFS_STAT, rd, rs);
    check("status", rd, 32'h3);
    // Unimplemented bits, then a single byte lane
    wrReg(8'h00, 32'hffffffff, 4'hf, RESP_OKAY);
    rdReg(8'h00, rd, rs);
    check("unimplBits", rd, 32'h0000ffeb);
    wrReg(8'h00, 32'h0, 4'h2, RESP_OKAY);
    rdReg(8'h00, rd, rs);
    check("byteLane", rd, 32'h000000eb);
    // Unmapped place answers with an error and reads zero
    wrReg(8'h1c, 32'hffff, 4'hf, RESP_SLVERR);
    rdReg(8'h1c, rd, rs);
    check("unmapResp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    check("unmapData", rd, 32'h0);
    // Reset in mid-run clears the masks again
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdReg(8'h00, rd, rs);
    check("midResetStd", rd, 32'h0);
    rdReg(OFS_EXT0, rd, rs);
    check("midResetExt", rd, 32'h0);
    tally_and_finish();
  end
endmodule : test_can_acceptance_mask_std_id
